// ---- vpr_clk_activity.sv ----
// pixel clock sensing: synchronises a foreign clock pin, gives rising edges and an activity level
// assumes the pin toggles far slower than core_clk (at least four core cycles per phase)
`timescale 1ns/1ps
`default_nettype none
module vpr_clk_activity #(
   parameter int TIMEOUT_CYC = 80,
   parameter int CW = 8
) (
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // async reset, high
   input wire logic ce, // clock enable
   input wire logic pclk_pin, // raw pixel clock pin
   output logic pclk_edge, // one-cycle rising edge pulse
   output logic pclk_active // clock seen recently
);
   logic s1_r; // first synchroniser stage
   logic s2_r; // second stage
   logic s3_r; // edge history
   logic [CW-1:0] idle_r; // cycles since last edge
   logic active_r; // activity flag

   assign pclk_edge = s2_r && !s3_r;
   assign pclk_active = active_r;

   // two-stage synchroniser plus history
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else if (ce) begin
         s1_r <= pclk_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // idle timeout: a stopped source drops out after TIMEOUT_CYC cycles
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         idle_r <= '0;
         active_r <= 1'b0;
      end else if (ce) begin
         if (pclk_edge) begin
            idle_r <= '0;
            active_r <= 1'b1;
         end else if (idle_r == CW'(TIMEOUT_CYC - 1)) begin
            active_r <= 1'b0;
         end else begin
            idle_r <= idle_r + 1'b1;
         end
      end
   end

   AST_IDLE_DROP: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ce && !pclk_edge && idle_r == CW'(TIMEOUT_CYC - 1)) |=> !active_r)
      else $error("activity flag kept after idle timeout");
endmodule : vpr_clk_activity
`default_nettype wire

// ---- vpr_fifo.sv ----
// small synchronous FIFO with valid/ready on both sides and a flush
// assumes one clock, a clock enable freezing everything, depth a power of two
`timescale 1ns/1ps
`default_nettype none
module vpr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // async reset, high
   input wire logic ce, // clock enable
   input wire logic flush, // drop all content
   input wire logic in_valid, // write request
   output logic in_ready, // room left
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid, // word available
   input wire logic out_ready, // drain request
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [AW-1:0] wptr_r; // write pointer
   logic [AW-1:0] rptr_r; // read pointer
   logic [AW:0] cnt_r; // fill level
   logic do_wr; // accepted write
   logic do_rd; // accepted read

   assign in_ready = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rptr_r];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   // storage write; no reset needed for data
   always_ff @(posedge core_clk) begin
      if (ce && do_wr) begin
         mem[wptr_r] <= in_data;
      end
   end

   // pointers and level; flush wins over traffic
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
      end else if (ce) begin
         if (flush) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
         end else begin
            if (do_wr) begin
               wptr_r <= wptr_r + 1'b1;
            end
            if (do_rd) begin
               rptr_r <= rptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
               cnt_r <= cnt_r + 1'b1;
            end else if (do_rd && !do_wr) begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end
endmodule : vpr_fifo
`default_nettype wire

// ---- vpr_pkg.sv ----
// types shared by the video port router files
// assumes nothing of its surroundings
package vpr_pkg;
   // one-hot source code; bit index equals activity vector index
   typedef enum logic [2:0] {
      VPR_SRC_S0 = 3'b001,
      VPR_SRC_S1 = 3'b010,
      VPR_SRC_EXT = 3'b100
   } vpr_src_e;
   // one pixel word
   typedef logic [15:0] vpr_pix_t;
endpackage : vpr_pkg

// ---- vpr_regs.svh ----
// register offsets, field positions, reset values and timing counts of the video port router
// assumes the includer wants plain `define constants only; nothing here creates logic
`ifndef VPR_REGS_SVH
`define VPR_REGS_SVH

// configuration space byte offsets
`define VPR_CTRL_OFF 8'h84
`define VPR_STAT_OFF 8'h88
`define VPR_ROUTE_OFF 8'h8C

// video_routing_control fields
`define VPR_CTRL_EN0 0
`define VPR_CTRL_EN1 1
`define VPR_CTRL_PRIO_LSB 2
`define VPR_CTRL_PRIO_MSB 4
`define VPR_CTRL_AUTO 5
`define VPR_CTRL_SEL 6
`define VPR_CTRL_OUTEN 7
`define VPR_CTRL_RST 8'h00

// pin_function_routing fields (three bits per pin)
`define VPR_ROUTE_RST 32'h0000_0000
`define VPR_MP0_LSB 0
`define VPR_MP1_LSB 4
`define VPR_MP2_LSB 8
`define VPR_MP3_LSB 12
`define VPR_MP4_LSB 16
`define VPR_MP_ZOOM 3'h7

// status word fields
`define VPR_STAT_SEL_LSB 0
`define VPR_STAT_ACT_LSB 3
`define VPR_STAT_OVR 6

// timing
`define VPR_CLK_NS 25
`define VPR_TIMEOUT_NS 2000
`define VPR_TIMEOUT_CYC (`VPR_TIMEOUT_NS / `VPR_CLK_NS)

`endif

// ---- vpr_router.sv ----
// video port router top: config registers, source sensing, priority routing, buffered output
// assumes config accesses come from a same-clock master; pixel pins are foreign and synchronised
// Function
// - buffered sixteen-bit path from source to output
// - socket choice always one socket, resets socket0
// - output enable turns video output terminals on
// - no data unless a socket enable set
// - selected socket disabled drives output lines low
// - auto mode senses clocks, switches multiplexer
// - manual routing follows control bit six
// - control bit five enables auto detection
// - auto detection off after reset
// - priority field orders the three sources
// - routing code seven makes pin external clock
// - routing code seven puts switch status out
// - switch status shows external source selected
// - status pin needs general-purpose enable too
`timescale 1ns/1ps
`default_nettype none
`include "vpr_regs.svh"
module vpr_router
   import vpr_pkg::*;
#(
   parameter int PIX_W = 16,
   parameter int FIFO_DEPTH = 8,
   parameter int TIMEOUT_CYC = `VPR_TIMEOUT_CYC
) (
   input wire logic core_clk, // 40 MHz core clock
   input wire logic sys_rst, // async reset, high
   input wire logic ce, // clock enable, freezes all state
   input wire logic cfg_wr, // config write strobe
   input wire logic cfg_rd, // config read strobe
   input wire logic [7:0] cfg_addr, // config byte address
   input wire logic [3:0] cfg_be, // byte enables
   input wire logic [31:0] cfg_wdata, // write data
   output logic [31:0] cfg_rdata, // read data, one cycle after strobe
   input wire logic gpio_stat_en, // general-purpose enable of switch status
   input wire logic sock0_pclk, // socket 0 pixel clock pin
   input wire logic [PIX_W-1:0] sock0_data, // socket 0 pixel pins
   input wire logic sock1_pclk, // socket 1 pixel clock pin
   input wire logic [PIX_W-1:0] sock1_data, // socket 1 pixel pins
   input wire logic [PIX_W-1:0] ext_data, // external source pixel pins
   input wire logic multipin_2_in, // multipin 2 input level
   input wire logic multipin_3_in, // multipin 3 input level
   output logic multipin_0_out, // multipin 0 output level
   output logic multipin_0_oe, // multipin 0 drive enable
   output logic multipin_1_out, // multipin 1 output level
   output logic multipin_1_oe, // multipin 1 drive enable
   output logic multipin_4_out, // multipin 4 output level
   output logic multipin_4_oe, // multipin 4 drive enable
   output logic vid_oe, // video output terminal enable
   output logic vid_valid, // output word valid
   input wire logic vid_ready, // display accepts word
   output logic [PIX_W-1:0] vid_data // output pixel word
);
   localparam int CW = $clog2(TIMEOUT_CYC + 1);

   // registers
   logic [7:0] ctrl_r; // video_routing_control
   logic [31:0] route_r; // pin_function_routing
   logic [31:0] rdata_r; // read data register
   logic ovr_r; // sticky overrun flag

   // control fields
   logic cfg_en0; // socket0_video_enable
   logic cfg_en1; // socket1_video_enable
   logic [2:0] cfg_prio; // priority order
   logic cfg_auto; // auto detection on
   logic cfg_choice; // output_socket_choice
   logic cfg_out_en; // video_output_enable

   // pin routing decode
   logic ext_on_mp2; // multipin 2 is clock sense
   logic ext_on_mp3; // multipin 3 is clock sense
   logic ext_sense_on; // an external clock sense pin exists
   logic ext_pclk_raw; // chosen raw external clock
   logic video_switch_status; // external source routed

   // sensing and routing
   logic [2:0] raw_pclk; // raw clocks by source index
   logic [3*PIX_W-1:0] raw_pix; // raw pixels by source index
   logic [2:0] src_edge; // rising edges by source
   logic [2:0] src_act_raw; // activity by source
   logic [2:0] src_act; // activity, ext gated by routing
   logic [3*PIX_W-1:0] src_pix; // synchronised pixels
   vpr_src_e manual_sel; // software choice
   vpr_src_e route_sel_r; // current route
   vpr_src_e route_sel_nxt; // next route
   logic route_ok; // selected source may pass
   logic route_chg; // route about to change
   logic sel_edge; // edge of routed source
   vpr_pix_t sel_pix; // pixel of routed source

   // data path
   logic pend_r; // captured pixel awaiting FIFO
   vpr_pix_t pend_data_r; // captured pixel
   logic fifo_in_ready; // FIFO has room
   logic fifo_out_valid; // FIFO head valid
   vpr_pix_t fifo_out_data; // FIFO head
   logic fifo_pop; // move head to output stage
   logic out_valid_r; // output stage valid
   vpr_pix_t out_data_r; // output stage data

   // config strobes
   logic wr_ctrl; // write to control
   logic wr_route; // write to routing
   logic wr_stat; // write to status

   // priority pick: first active source of the ordered list, else manual choice
   function automatic vpr_src_e vpr_pick(input logic [2:0] prio, input logic [2:0] act,
                                         input vpr_src_e dflt);
      vpr_src_e o1;
      vpr_src_e o2;
      vpr_src_e o3;
      unique case (prio)
         3'h1: begin o1 = VPR_SRC_S0; o2 = VPR_SRC_EXT; o3 = VPR_SRC_S1; end
         3'h2: begin o1 = VPR_SRC_S1; o2 = VPR_SRC_S0; o3 = VPR_SRC_EXT; end
         3'h3: begin o1 = VPR_SRC_S1; o2 = VPR_SRC_EXT; o3 = VPR_SRC_S0; end
         3'h4: begin o1 = VPR_SRC_EXT; o2 = VPR_SRC_S0; o3 = VPR_SRC_S1; end
         3'h5, 3'h6: begin o1 = VPR_SRC_EXT; o2 = VPR_SRC_S1; o3 = VPR_SRC_S0; end
         // reserved code falls back to the plain socket order
         default: begin o1 = VPR_SRC_S0; o2 = VPR_SRC_S1; o3 = VPR_SRC_EXT; end
      endcase
      if ((act & o1) != 3'h0) begin
         return o1;
      end else if ((act & o2) != 3'h0) begin
         return o2;
      end else if ((act & o3) != 3'h0) begin
         return o3;
      end
      return dflt;
   endfunction : vpr_pick

   // field extraction
   assign cfg_en0 = ctrl_r[`VPR_CTRL_EN0];
   assign cfg_en1 = ctrl_r[`VPR_CTRL_EN1];
   assign cfg_prio = ctrl_r[`VPR_CTRL_PRIO_MSB:`VPR_CTRL_PRIO_LSB];
   assign cfg_auto = ctrl_r[`VPR_CTRL_AUTO];
   assign cfg_choice = ctrl_r[`VPR_CTRL_SEL];
   assign cfg_out_en = ctrl_r[`VPR_CTRL_OUTEN];

   // config decode; only the documented lanes matter per register
   assign wr_ctrl = cfg_wr && (cfg_addr == `VPR_CTRL_OFF) && cfg_be[0];
   assign wr_route = cfg_wr && (cfg_addr == `VPR_ROUTE_OFF);
   assign wr_stat = cfg_wr && (cfg_addr == `VPR_STAT_OFF) && cfg_be[0];

   // control register; reset leaves auto off and socket 0 chosen
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= `VPR_CTRL_RST;
      end else if (ce && wr_ctrl) begin
         ctrl_r <= cfg_wdata[7:0];
      end
   end

   // routing register, byte lanes written independently
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         route_r <= `VPR_ROUTE_RST;
      end else if (ce && wr_route) begin
         for (int b = 0; b < 4; b++) begin
            if (cfg_be[b]) begin
               route_r[b*8 +: 8] <= cfg_wdata[b*8 +: 8];
            end
         end
      end
   end

   // read mux registered; unmapped addresses read zero
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (ce && cfg_rd) begin
         unique case (cfg_addr)
            `VPR_CTRL_OFF: rdata_r <= {24'h00_0000, ctrl_r};
            `VPR_ROUTE_OFF: rdata_r <= route_r;
            `VPR_STAT_OFF: rdata_r <= {25'h000_0000, ovr_r, src_act, route_sel_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end
   assign cfg_rdata = rdata_r;

   // multipin decode for the external clock sense input
   assign ext_on_mp2 = (route_r[`VPR_MP2_LSB +: 3] == `VPR_MP_ZOOM);
   assign ext_on_mp3 = (route_r[`VPR_MP3_LSB +: 3] == `VPR_MP_ZOOM);
   assign ext_sense_on = ext_on_mp2 || ext_on_mp3;
   // mux before the synchroniser; a glitch on reprogramming only costs one false edge
   assign ext_pclk_raw = ext_on_mp3 ? multipin_3_in : (ext_on_mp2 && multipin_2_in);

   assign raw_pclk = {ext_pclk_raw, sock1_pclk, sock0_pclk};
   assign raw_pix = {ext_data, sock1_data, sock0_data};

   // per-source synchronisers and clock sensing
   generate
      for (genvar i = 0; i < 3; i++) begin : g_src
         logic [PIX_W-1:0] d1_r; // first data stage
         logic [PIX_W-1:0] d2_r; // second data stage
         // data passes two flops, aligned with the clock edge detector
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               d1_r <= '0;
               d2_r <= '0;
            end else if (ce) begin
               d1_r <= raw_pix[i*PIX_W +: PIX_W];
               d2_r <= d1_r;
            end
         end
         vpr_clk_activity #(
            .TIMEOUT_CYC(TIMEOUT_CYC),
            .CW(CW)
         ) u_act (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .ce(ce),
            .pclk_pin(raw_pclk[i]),
            .pclk_edge(src_edge[i]),
            .pclk_active(src_act_raw[i])
         );
         assign src_pix[i*PIX_W +: PIX_W] = d2_r;
      end
   endgenerate

   // external source only counts when a sense pin is routed
   assign src_act = {src_act_raw[2] && ext_sense_on, src_act_raw[1:0]};

   // route choice: manual bits, or priority pick in auto mode
   assign manual_sel = cfg_choice ? VPR_SRC_S1 : VPR_SRC_S0;
   assign route_sel_nxt = cfg_auto ? vpr_pick(cfg_prio, src_act, manual_sel) : manual_sel;
   assign route_chg = (route_sel_nxt != route_sel_r);

   // current route register, always one-hot
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         route_sel_r <= VPR_SRC_S0;
      end else if (ce) begin
         route_sel_r <= route_sel_nxt;
      end
   end

   // gate: socket needs its own enable, external needs any enable and its sense pin
   always_comb begin
      route_ok = 1'b0;
      unique case (route_sel_r)
         VPR_SRC_S0: route_ok = cfg_en0;
         VPR_SRC_S1: route_ok = cfg_en1;
         VPR_SRC_EXT: route_ok = (cfg_en0 || cfg_en1) && ext_sense_on;
         default: route_ok = 1'b0;
      endcase
   end

   assign sel_edge = |(src_edge & route_sel_r);
   assign sel_pix = route_sel_r[2] ? src_pix[2*PIX_W +: PIX_W] :
                    route_sel_r[1] ? src_pix[PIX_W +: PIX_W] : src_pix[PIX_W-1:0];

   // capture stage: one pixel per routed clock edge
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_r <= 1'b0;
         pend_data_r <= '0;
      end else if (ce) begin
         if (route_chg || !route_ok) begin
            pend_r <= 1'b0;
         end else if (sel_edge) begin
            pend_r <= 1'b1;
            pend_data_r <= sel_pix;
         end else if (fifo_in_ready) begin
            pend_r <= 1'b0;
         end
      end
   end

   // overrun: a pixel arrived while the previous one was still blocked; set beats clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ovr_r <= 1'b0;
      end else if (ce) begin
         if (sel_edge && pend_r && !fifo_in_ready && route_ok) begin
            ovr_r <= 1'b1;
         end else if (wr_stat && cfg_wdata[`VPR_STAT_OVR]) begin
            ovr_r <= 1'b0;
         end
      end
   end

   // buffer between pixel capture and display; flushed on every route change
   vpr_fifo #(
      .WIDTH(PIX_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .flush(route_chg || !route_ok),
      .in_valid(pend_r),
      .in_ready(fifo_in_ready),
      .in_data(pend_data_r),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // drain only while terminals enabled and the output stage can take a word
   assign fifo_pop = fifo_out_valid && cfg_out_en && route_ok && (!out_valid_r || vid_ready);

   // output stage; a disabled route forces every line low
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end else if (ce) begin
         if (!route_ok || route_chg || !cfg_out_en) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
         end else if (fifo_pop) begin
            out_valid_r <= 1'b1;
            out_data_r <= fifo_out_data;
         end else if (vid_ready) begin
            out_valid_r <= 1'b0;
         end
      end
   end

   assign vid_oe = cfg_out_en;
   assign vid_valid = out_valid_r && route_ok && cfg_out_en; // no stale word after disable
   assign vid_data = out_data_r;

   // switch status drives external buffers of the motherboard source
   assign video_switch_status = (route_sel_r == VPR_SRC_EXT);
   assign multipin_0_out = video_switch_status;
   assign multipin_1_out = video_switch_status;
   assign multipin_4_out = video_switch_status;
   assign multipin_0_oe = gpio_stat_en && (route_r[`VPR_MP0_LSB +: 3] == `VPR_MP_ZOOM);
   assign multipin_1_oe = gpio_stat_en && (route_r[`VPR_MP1_LSB +: 3] == `VPR_MP_ZOOM);
   assign multipin_4_oe = gpio_stat_en && (route_r[`VPR_MP4_LSB +: 3] == `VPR_MP_ZOOM);

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_push;
      ce && sel_edge && route_ok && !route_chg;
   endsequence
   sequence s_auto;
      ce && cfg_auto;
   endsequence

   AST_SEL_ONEHOT: assert property ($onehot(route_sel_r))
      else $error("route select not one-hot");
   AST_CAPTURE: assert property (s_push |=> (pend_r && pend_data_r == $past(sel_pix)))
      else $error("routed pixel not captured");
   AST_NO_ENABLE: assert property (vid_valid |-> (cfg_en0 || cfg_en1) && vid_oe)
      else $error("data sent without socket enable");
   AST_DISABLED_LOW: assert property ((ce && !route_ok) |=> (vid_data == '0 && !vid_valid))
      else $error("disabled socket not driven low");
   AST_MANUAL: assert property ((ce && !cfg_auto) |=> route_sel_r == $past(manual_sel))
      else $error("manual routing ignored");
   AST_AUTO_WR: assert property ((ce && wr_ctrl && cfg_wdata[`VPR_CTRL_AUTO]) |=> cfg_auto)
      else $error("auto enable write lost");
   AST_PRIO_A: assert property ((s_auto and cfg_prio == 3'h0 && src_act[0]) |=>
      route_sel_r == VPR_SRC_S0) else $error("priority 000 wrong pick");
   AST_PRIO_EXT: assert property ((s_auto and cfg_prio == 3'h5 && src_act[2]) |=>
      route_sel_r == VPR_SRC_EXT && video_switch_status) else $error("priority 101 wrong pick");
   AST_EXT_ROUTE: assert property ((ce && cfg_auto && !ext_sense_on) |=> route_sel_r != VPR_SRC_EXT)
      else $error("external chosen without sense pin");
   AST_STAT_PIN: assert property ((multipin_0_oe || multipin_1_oe || multipin_4_oe) |-> gpio_stat_en)
      else $error("status pin driven without enable");
endmodule : vpr_router
`default_nettype wire

// ---- vpr_router_bench.sv ----
// self-checking bench of the video port router
// assumes source models at 200 ns pixel period and a 40 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module vpr_router_bench;
   import vpr_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
   logic gpio_stat_en = 1'b0, vid_ready = 1'b1;
   logic [7:0] cfg_addr = 8'h00;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0000_0000, cfg_rdata, rd;
   wire logic p0, p1, px;
   wire logic [15:0] d0, d1, dx;
   logic vid_oe, vid_valid;
   wire logic [2:0] mp_out, mp_oe; // status pins 0, 1 and 4
   vpr_pix_t vid_data;
   vpr_pix_t got[$]; // words taken by the display
   int n_fail = 0, samples_checked = 0;
   always #12.5 core_clk = ~core_clk;
   vpr_src_model s0 (.pclk(p0), .pix(d0));
   vpr_src_model s1 (.pclk(p1), .pix(d1));
   vpr_src_model sx (.pclk(px), .pix(dx));
   // short timeout keeps stopped sources from lingering
   vpr_router #(.TIMEOUT_CYC(12)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .gpio_stat_en(gpio_stat_en),
      .sock0_pclk(p0), .sock0_data(d0), .sock1_pclk(p1), .sock1_data(d1), .ext_data(dx),
      .multipin_2_in(px), .multipin_3_in(1'b0), .multipin_0_out(mp_out[0]),
      .multipin_0_oe(mp_oe[0]), .multipin_1_out(mp_out[1]), .multipin_1_oe(mp_oe[1]),
      .multipin_4_out(mp_out[2]), .multipin_4_oe(mp_oe[2]), .vid_oe(vid_oe),
      .vid_valid(vid_valid), .vid_ready(vid_ready),
      .vid_data(vid_data));
   // display side collects every accepted word
   always @(posedge core_clk) if (vid_valid && vid_ready) got.push_back(vid_data);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   // one config access; read data stands from the cycle after the taking edge
   task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(negedge core_clk);
      {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {wr, !wr, a, 4'hF, wd};
      @(negedge core_clk);
      {cfg_wr, cfg_rd} = 2'b00;
      @(negedge core_clk);
      rd = cfg_rdata;
   endtask : cfg
   // manual routing: control c, four words from one socket, passed or blocked
   task automatic man(input logic [7:0] c, input int src, input int ok);
      logic [15:0] b;
      b = src ? 16'hB0 : 16'hA0;
      got.delete();
      cfg(1, 8'h84, {24'h0, c});
      if (src == 0) s0.send(4, b);
      else s1.send(4, b);
      repeat (10) @(negedge core_clk);
      check(vid_oe, c[7]);
      check(got.size(), ok ? 4 : 0);
      foreach (got[i]) check(got[i], b + i);
      check(vid_data, ok ? b + 3 : 0);
      cfg(0, 8'h84, 0);
      check(rd, c);
      $display("test manual %h done", c);
   endtask : man
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      finish_test();
   end
   // reset values of both registers and of the output terminals
   task automatic t_reset();
      cfg(0, 8'h84, 0);
      check(rd, 0);
      cfg(0, 8'h8C, 0);
      check(rd, 0);
      check({vid_oe, vid_data}, 0);
      $display("test reset done");
   endtask : t_reset
   // display stalls: output stage, 8 buffered, 1 pending; later words overwrite the pending one
   task automatic t_buffer();
      got.delete();
      vid_ready = 1'b0;
      cfg(1, 8'h84, 32'h81);
      s0.send(12, 16'hC0);
      cfg(0, 8'h88, 0);
      check(rd[6], 1'b1);
      check(vid_data, 16'hC0);
      vid_ready = 1'b1;
      repeat (20) @(negedge core_clk);
      check(got[0], 16'hC0);
      check(got.size(), 10);
      check(got[9], 16'hCB);
      cfg(1, 8'h88, 32'h40);
      cfg(0, 8'h88, 0);
      check(rd[6], 1'b0);
      $display("test buffer done");
   endtask : t_buffer
   // auto mode: socket 0 and external run together under every priority code
   task automatic t_auto();
      cfg(1, 8'h8C, 32'h0007_0777);
      gpio_stat_en = 1'b1;
      fork
         s0.send(60, 16'h0010);
         sx.send(60, 16'h0020);
         begin
            for (int p = 0; p < 8; p++) begin
               cfg(1, 8'h84, {24'h0, 8'(8'hA3 | (p << 2))});
               repeat (8) @(negedge core_clk);
               cfg(0, 8'h88, 0);
               check(rd[2:0], (p inside {[3:6]}) ? 3'b100 : 3'b001);
               check(mp_out, (p inside {[3:6]}) ? 3'h7 : 3'h0);
               check(mp_oe, 3'h7);
            end
            cfg(1, 8'h84, 32'hB3);
         end
      join
      repeat (10) @(negedge core_clk);
      check(got[$], 16'h0020 + 59);
      gpio_stat_en = 1'b0;
      repeat (30) @(negedge core_clk);
      check({mp_out, mp_oe}, 6'h00);
      cfg(0, 8'h88, 0);
      check(rd[5:0], 6'h01);
      $display("test auto done");
   endtask : t_auto
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk) sys_rst = 1'b0;
      t_reset();
      man(8'h81, 0, 1);
      man(8'hC2, 1, 1);
      man(8'hC1, 1, 0);
      man(8'h82, 0, 0);
      man(8'hC0, 1, 0);
      man(8'h40, 1, 0);
      t_buffer();
      t_auto();
      finish_test();
   end
endmodule : vpr_router_bench
`default_nettype wire

// ---- vpr_src_model.sv ----
// pixel source model: pixel clock and 16-bit words of one video source
// assumes the router samples these pins with its own clock
`timescale 1ns/1ps
`default_nettype none
module vpr_src_model (
   output logic pclk, // pixel clock, still outside frames
   output logic [15:0] pix // pixel word
);
   initial begin
      pclk = 1'b0;
      pix = 16'h0000;
   end
   // one word per rising edge, set half a period early; 200 ns period
   task automatic send(input int n, input logic [15:0] base);
      #7;
      for (int i = 0; i < n; i++) begin
         pix = base + i[15:0];
         #100 pclk = 1'b1;
         #100 pclk = 1'b0;
      end
      pix = ~pix; // frame over: never leave a stale word
   endtask : send
endmodule : vpr_src_model
`default_nettype wire
